// ===== shared/lific_pkg.sv
// Constants for the line interface control and idle code register bank
// Functional notes
// - Monitor gain code selects receive boost of 0, 20, 26 or 32 dB.
// - Receive sync clock enable turns the sync receive mode on or off.
// - Transmit sync clock enable turns the transmit sync clock on or off.
// - Alternating pattern enable sends 1010 on the line, timed by line clock.
// - Bit 7 of control four enables CMI line coding.
// - CMI inversion bit inverts CMI on transmit and receive tip lines.
// - Prescaler with jitter clock source states the master clock frequency.
// - Transmit termination field selects off, 75, 100 or 120 ohms.
// - Receive termination field selects off, 75, 100 or 120 ohms.
// - Gain target adjusts amplitude while automatic gain control is in use.
// - Two slew reduction bits form a binary weighted value.
// - Slew boost A top two bits carry equal weight, bit 4 the MSB.
// - Global receive update loads the code into every receive entry.
// - Global transmit update loads the code into every transmit entry.
// - Both globals clear updates one channel; both set updates all.
// - Six-bit pointer selects the channel; channel one is 01h.
// - Eight-bit code supplies the channel value; bit 0 is sent last.
// - Enabled transmit channels carry the idle array code instead of data.
// - E1/T1 select picks T1 at 0, E1 at 1, setting range and clocks.
package lific_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CHAN_N = 32;
  localparam int CHAN_W = 5;
  // Register offsets
  localparam logic [7:0] OFS_LIC2 = 8'h79;
  localparam logic [7:0] OFS_LIC3 = 8'h7A;
  localparam logic [7:0] OFS_LIC4 = 8'h7B;
  localparam logic [7:0] OFS_TLBC = 8'h7D;
  localparam logic [7:0] OFS_PTR = 8'h7E;
  localparam logic [7:0] OFS_CODE = 8'h7F;
  localparam logic [7:0] OFS_TXEN1 = 8'h80;
  localparam logic [7:0] OFS_TXEN4 = 8'h83;
  localparam logic [7:0] OFS_PSA1 = 8'hF1;
  localparam logic [7:0] OFS_PSA2 = 8'hF2;
  localparam logic [7:0] OFS_CFG = 8'h60;
  localparam logic [7:0] RST_VAL = 8'h00;
  // Writable bit masks
  localparam logic [7:0] MSK_LIC2 = 8'h88;
  localparam logic [7:0] MSK_LIC3 = 8'h1F;
  localparam logic [7:0] MSK_TLBC = 8'h40;
  localparam logic [7:0] MSK_PSA1 = 8'h3F;
  localparam logic [7:0] MSK_PSA2 = 8'h88;
  localparam logic [7:0] MSK_CFG = 8'h01;
  // Field positions
  localparam int B_E1_SEL = 7;
  localparam int B_JIT_SRC = 3;
  localparam int B_MG_HI = 4;
  localparam int B_MG_LO = 3;
  localparam int B_RSCLK = 2;
  localparam int B_TSCLK = 1;
  localparam int B_AOZ = 0;
  localparam int B_CMI_EN = 7;
  localparam int B_CMI_INV = 6;
  localparam int B_MPS_HI = 5;
  localparam int B_MPS_LO = 4;
  localparam int B_TT_HI = 3;
  localparam int B_TT_LO = 2;
  localparam int B_RT_HI = 1;
  localparam int B_RT_LO = 0;
  localparam int B_AGC_OFF = 6;
  localparam int B_TGT2 = 5;
  localparam int B_SLOW1 = 4;
  localparam int B_TGT1 = 3;
  localparam int B_SLOW0 = 2;
  localparam int B_TGT0 = 1;
  localparam int B_SRIB = 0;
  localparam int B_BOOST_A4 = 7;
  localparam int B_BOOST_A3 = 3;
  localparam int B_GLB_RX = 7;
  localparam int B_GLB_TX = 6;
  localparam int B_RXSEL = 0;
  // Decode values
  localparam logic [5:0] GAIN_DB_01 = 6'h14;
  localparam logic [5:0] GAIN_DB_10 = 6'h1A;
  localparam logic [5:0] GAIN_DB_11 = 6'h20;
  localparam logic [6:0] OHM_01 = 7'h4B;
  localparam logic [6:0] OHM_10 = 7'h64;
  localparam logic [6:0] OHM_11 = 7'h78;
  localparam logic [14:0] MCLK_T1_KHZ = 15'h0608;
  localparam logic [14:0] MCLK_E1_KHZ = 15'h0800;
  localparam logic [4:0] SRIA_TOP_WEIGHT = 5'h08;
  localparam logic [5:0] CHAN_MAX_T1 = 6'h18;
  localparam logic [5:0] CHAN_MAX_E1 = 6'h20;
  localparam logic signed [7:0] AMP_PCT [8] = '{8'sh00, -8'sh17, -8'sh0F, -8'sh08,
                                               8'sh06, 8'sh0A, 8'sh0F, 8'sh23};
endpackage : lific_pkg

// ===== hw/lific_sync3.sv
// Three-stage input synchroniser with agreement filter
module lific_sync3
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic async_i,
  output logic level_o
);
  import lific_pkg::*;

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a new level once stages two and three agree
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      level_o <= 1'b0;
    else if (s2_reg == s3_reg)
      level_o <= s3_reg;
  end
endmodule : lific_sync3

// ===== hw/lific_regs.sv
// Line interface control and idle code register bank
//
// Chosen here: the strobed register port.
module lific_regs
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [lific_pkg::ADDR_W-1:0] addr_i,
  input wire logic [lific_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [lific_pkg::DATA_W-1:0] rd_data_o,
  input wire logic tx_line_clock_i,
  input wire logic tx_chan_valid_i,
  input wire logic [lific_pkg::CHAN_W-1:0] tx_chan_i,
  input wire logic [7:0] tx_chan_data_i,
  output logic tx_chan_valid_o,
  output logic [7:0] tx_chan_data_o,
  output logic [5:0] monitor_gain_db_o,
  output logic rx_sync_mode_o,
  output logic tx_sync_clock_en_o,
  output logic alt_pattern_active_o,
  output logic alt_pattern_o,
  output logic cmi_enable_o,
  output logic cmi_invert_tx_o,
  output logic cmi_invert_rx_o,
  output logic [14:0] mclk_khz_o,
  output logic [6:0] tx_term_ohm_o,
  output logic [6:0] rx_term_ohm_o,
  output logic e1_mode_o,
  output logic [5:0] gain_adjust_code_o,
  output logic signed [7:0] amplitude_pct_o,
  output logic [1:0] slew_reduce_o,
  output logic [4:0] slew_boost_a_o,
  output logic slew_boost_b_o
);
  import lific_pkg::*;

  logic [7:0] lic2_reg;
  logic [7:0] lic3_reg;
  logic [7:0] lic4_reg;
  logic [7:0] tlbc_reg;
  logic [7:0] ptr_reg;
  logic [7:0] code_reg;
  logic [7:0] psa1_reg;
  logic [7:0] psa2_reg;
  logic [7:0] cfg_reg;
  logic [CHAN_N-1:0] txen_reg;
  logic [7:0] tx_mem [CHAN_N];
  logic [7:0] rx_mem [CHAN_N];
  logic [7:0] rd_next;
  logic [7:0] code_rd;
  logic [7:0] tx_ins_val;
  logic code_wr;
  logic ptr_ok;
  logic [CHAN_W-1:0] ptr_idx;
  logic line_clk_lvl;
  logic line_clk_prev_reg;
  logic line_rise;

  // Ohm value of a termination field
  function automatic logic [6:0] term_ohm(input logic [1:0] sel);
    case (sel)
      2'b01: term_ohm = OHM_01;
      2'b10: term_ohm = OHM_10;
      2'b11: term_ohm = OHM_11;
      default: term_ohm = 7'h00;
    endcase
  endfunction : term_ohm

  // Pointer lies in the channel range of the current line mode
  function automatic logic chan_ok(input logic [5:0] ptr, input logic e1);
    chan_ok = (ptr != 6'h00) && (ptr <= (e1 ? CHAN_MAX_E1 : CHAN_MAX_T1));
  endfunction : chan_ok

  // Pointer decode; channel one sits at entry zero
  assign ptr_idx = CHAN_W'(ptr_reg[5:0] - 6'h01);
  assign ptr_ok = chan_ok(ptr_reg[5:0], lic2_reg[B_E1_SEL]);
  assign code_wr = wr_en_i && (addr_i == OFS_CODE);

  // Line control registers; only defined bits are stored
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lic2_reg <= RST_VAL;
      lic3_reg <= RST_VAL;
      lic4_reg <= RST_VAL;
      tlbc_reg <= RST_VAL;
      cfg_reg <= RST_VAL;
    end
    else if (wr_en_i)
    begin
      if (addr_i == OFS_LIC2)
        lic2_reg <= wr_data_i & MSK_LIC2;
      if (addr_i == OFS_LIC3)
        lic3_reg <= wr_data_i & MSK_LIC3;
      if (addr_i == OFS_LIC4)
        lic4_reg <= wr_data_i;
      if (addr_i == OFS_TLBC)
        tlbc_reg <= wr_data_i & MSK_TLBC;
      if (addr_i == OFS_CFG)
        cfg_reg <= wr_data_i & MSK_CFG;
    end
  end

  // Pulse shape registers; unused bits are dropped
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      psa1_reg <= RST_VAL;
      psa2_reg <= RST_VAL;
    end
    else if (wr_en_i)
    begin
      if (addr_i == OFS_PSA1)
        psa1_reg <= wr_data_i & MSK_PSA1;
      if (addr_i == OFS_PSA2)
        psa2_reg <= wr_data_i & MSK_PSA2;
    end
  end

  // Idle array pointer and code register
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ptr_reg <= RST_VAL;
      code_reg <= RST_VAL;
    end
    else
    begin
      if (wr_en_i && (addr_i == OFS_PTR))
        ptr_reg <= wr_data_i;
      if (code_wr)
        code_reg <= wr_data_i;
    end
  end

  // Transmit idle enables, one byte per eight channels
  genvar g;
  generate
    for (g = 0; g < CHAN_N / 8; g++)
    begin : g_txen
      always_ff @(posedge mclk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          txen_reg[g*8 +: 8] <= RST_VAL;
        else if (wr_en_i && (addr_i == 8'(OFS_TXEN1 + g)))
          txen_reg[g*8 +: 8] <= wr_data_i;
      end
    end
  endgenerate

  // Transmit idle entries, loaded on a code write
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < CHAN_N; i++)
        tx_mem[i] <= RST_VAL;
    end
    else if (code_wr)
    begin
      if (ptr_reg[B_GLB_TX])
      begin
        for (int i = 0; i < CHAN_N; i++)
          tx_mem[i] <= wr_data_i;
      end
      else if (!ptr_reg[B_GLB_RX] && !cfg_reg[B_RXSEL] && ptr_ok)
        tx_mem[ptr_idx] <= wr_data_i;
    end
  end

  // Receive idle entries, loaded on a code write
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < CHAN_N; i++)
        rx_mem[i] <= RST_VAL;
    end
    else if (code_wr)
    begin
      if (ptr_reg[B_GLB_RX])
      begin
        for (int i = 0; i < CHAN_N; i++)
          rx_mem[i] <= wr_data_i;
      end
      else if (!ptr_reg[B_GLB_TX] && cfg_reg[B_RXSEL] && ptr_ok)
        rx_mem[ptr_idx] <= wr_data_i;
    end
  end

  // Code read goes through the pointer only with both globals clear
  always_comb
  begin
    if (ptr_reg[B_GLB_RX] || ptr_reg[B_GLB_TX])
      code_rd = code_reg;
    else if (!ptr_ok)
      code_rd = 8'h00;
    else if (cfg_reg[B_RXSEL])
      code_rd = rx_mem[ptr_idx];
    else
      code_rd = tx_mem[ptr_idx];
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb
  begin
    case (addr_i)
      OFS_LIC2: rd_next = lic2_reg;
      OFS_LIC3: rd_next = lic3_reg;
      OFS_LIC4: rd_next = lic4_reg;
      OFS_TLBC: rd_next = tlbc_reg;
      OFS_PTR: rd_next = ptr_reg;
      OFS_CODE: rd_next = code_rd;
      OFS_TXEN1: rd_next = txen_reg[7:0];
      8'(OFS_TXEN1 + 8'h01): rd_next = txen_reg[15:8];
      8'(OFS_TXEN1 + 8'h02): rd_next = txen_reg[23:16];
      8'(OFS_TXEN1 + 8'h03): rd_next = txen_reg[31:24];
      OFS_PSA1: rd_next = psa1_reg;
      OFS_PSA2: rd_next = psa2_reg;
      OFS_CFG: rd_next = cfg_reg;
      default: rd_next = 8'h00;
    endcase
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rd_data_o <= 8'h00;
    else
      rd_data_o <= rd_en_i ? rd_next : 8'h00;
  end

  // Decoded line interface controls
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      monitor_gain_db_o <= 6'h00;
      rx_sync_mode_o <= 1'b0;
      tx_sync_clock_en_o <= 1'b0;
      alt_pattern_active_o <= 1'b0;
      cmi_enable_o <= 1'b0;
      cmi_invert_tx_o <= 1'b0;
      cmi_invert_rx_o <= 1'b0;
      mclk_khz_o <= 15'h0000;
      tx_term_ohm_o <= 7'h00;
      rx_term_ohm_o <= 7'h00;
      e1_mode_o <= 1'b0;
    end
    else
    begin
      case (lic3_reg[B_MG_HI:B_MG_LO])
        2'b01: monitor_gain_db_o <= GAIN_DB_01;
        2'b10: monitor_gain_db_o <= GAIN_DB_10;
        2'b11: monitor_gain_db_o <= GAIN_DB_11;
        default: monitor_gain_db_o <= 6'h00;
      endcase
      rx_sync_mode_o <= lic3_reg[B_RSCLK];
      tx_sync_clock_en_o <= lic3_reg[B_TSCLK];
      alt_pattern_active_o <= lic3_reg[B_AOZ];
      cmi_enable_o <= lic4_reg[B_CMI_EN];
      cmi_invert_tx_o <= lic4_reg[B_CMI_INV];
      cmi_invert_rx_o <= lic4_reg[B_CMI_INV];
      // Base rate is T1 only for T1 mode with master clock source
      mclk_khz_o <= (lic2_reg[B_E1_SEL] || lic2_reg[B_JIT_SRC]) ?
                    15'(MCLK_E1_KHZ << lic4_reg[B_MPS_HI:B_MPS_LO]) :
                    15'(MCLK_T1_KHZ << lic4_reg[B_MPS_HI:B_MPS_LO]);
      tx_term_ohm_o <= term_ohm(lic4_reg[B_TT_HI:B_TT_LO]);
      rx_term_ohm_o <= term_ohm(lic4_reg[B_RT_HI:B_RT_LO]);
      e1_mode_o <= lic2_reg[B_E1_SEL];
    end
  end

  // Decoded pulse shape controls
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gain_adjust_code_o <= 6'h00;
      amplitude_pct_o <= 8'sh00;
      slew_reduce_o <= 2'b00;
      slew_boost_a_o <= 5'h00;
      slew_boost_b_o <= 1'b0;
    end
    else
    begin
      if (!tlbc_reg[B_AGC_OFF])
      begin
        gain_adjust_code_o <= {psa1_reg[B_TGT2], 1'b0, psa1_reg[B_TGT1], 1'b0,
                               psa1_reg[B_TGT0], 1'b0};
        amplitude_pct_o <= AMP_PCT[{psa1_reg[B_TGT2], psa1_reg[B_TGT1], psa1_reg[B_TGT0]}];
      end
      else
      begin
        gain_adjust_code_o <= 6'h00;
        amplitude_pct_o <= 8'sh00;
      end
      slew_reduce_o <= {psa1_reg[B_SLOW1], psa1_reg[B_SLOW0]};
      slew_boost_a_o <= 5'((psa2_reg[B_BOOST_A4] ? SRIA_TOP_WEIGHT : 5'h00) +
                           (psa2_reg[B_BOOST_A3] ? SRIA_TOP_WEIGHT : 5'h00));
      slew_boost_b_o <= psa1_reg[B_SRIB];
    end
  end

  // Transmit line clock brought into the register clock domain
  lific_sync3 u_line_clk_sync
  (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .async_i(tx_line_clock_i),
    .level_o(line_clk_lvl)
  );

  // Rising edge of the filtered line clock
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      line_clk_prev_reg <= 1'b0;
    else
      line_clk_prev_reg <= line_clk_lvl;
  end
  assign line_rise = line_clk_lvl && !line_clk_prev_reg;

  // Alternating ones and zeros, one bit per line clock
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      alt_pattern_o <= 1'b0;
    else if (!lic3_reg[B_AOZ])
      alt_pattern_o <= 1'b0;
    else if (line_rise)
      alt_pattern_o <= !alt_pattern_o;
  end

  // Idle code insertion on the transmit channel stream
  assign tx_ins_val = tx_mem[tx_chan_i];
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_chan_valid_o <= 1'b0;
      tx_chan_data_o <= 8'h00;
    end
    else
    begin
      tx_chan_valid_o <= tx_chan_valid_i;
      tx_chan_data_o <= txen_reg[tx_chan_i] ? tx_ins_val : tx_chan_data_i;
    end
  end

  // Checks on decode and idle array behaviour
  AST_GAIN_26: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == OFS_LIC3 && wr_data_i[B_MG_HI:B_MG_LO] == 2'b10
    |-> ##2 monitor_gain_db_o == 6'h1A) else $error("gain boost not 26 dB");
  AST_RX_SYNC: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == OFS_LIC3 |-> ##2 rx_sync_mode_o == $past(wr_data_i[B_RSCLK], 2))
    else $error("rx sync mode does not follow write");
  AST_TX_SYNC: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == OFS_LIC3 && !wr_data_i[B_TSCLK] |-> ##2 !tx_sync_clock_en_o)
    else $error("tx sync clock not disabled");
  AST_ALT_EDGE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $changed(alt_pattern_o) && alt_pattern_o |-> $past(line_rise))
    else $error("pattern moved without line clock edge");
  AST_CMI_EN: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == OFS_LIC4 |-> ##2 cmi_enable_o == $past(wr_data_i[B_CMI_EN], 2))
    else $error("cmi enable does not follow bit 7");
  AST_TX_TERM: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == OFS_LIC4 && wr_data_i[B_TT_HI:B_TT_LO] == 2'b01
    |-> ##2 tx_term_ohm_o == 7'h4B) else $error("tx termination not 75 ohm");
  AST_RX_TERM: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == OFS_LIC4 && wr_data_i[B_RT_HI:B_RT_LO] == 2'b11
    |-> ##2 rx_term_ohm_o == 7'h78) else $error("rx termination not 120 ohm");
  AST_AGC_GATE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    tlbc_reg[B_AGC_OFF] |-> ##1 amplitude_pct_o == 8'sh00 && gain_adjust_code_o == 6'h00)
    else $error("amplitude adjusted without gain control");
  AST_GLOBAL_RX: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    code_wr && ptr_reg[B_GLB_RX] |=> rx_mem[5] == $past(wr_data_i) && rx_mem[31] == code_reg)
    else $error("global receive update missed an entry");
  AST_GLOBAL_TX: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    code_wr && ptr_reg[B_GLB_TX] |=> tx_mem[3] == $past(wr_data_i) && tx_mem[30] == code_reg)
    else $error("global transmit update missed an entry");
  AST_SINGLE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    code_wr && ptr_reg == 8'h01 && !cfg_reg[B_RXSEL]
    |=> tx_mem[0] == $past(wr_data_i) && $stable(tx_mem[1]) && $stable(rx_mem[0]))
    else $error("single update wrong");
  AST_T1_RANGE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    code_wr && ptr_reg == 8'h19 && !lic2_reg[B_E1_SEL] && !cfg_reg[B_RXSEL]
    |=> $stable(tx_mem[24])) else $error("T1 write beyond channel 24");
  AST_INSERT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    tx_chan_valid_i |=> tx_chan_data_o == ($past(txen_reg[tx_chan_i]) ?
    $past(tx_ins_val) : $past(tx_chan_data_i))) else $error("idle insertion wrong");
  AST_RD_SLOT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !rd_en_i |=> rd_data_o == 8'h00) else $error("read data outside slot");
endmodule : lific_regs

// ===== verification/lific_regs_tb.sv
// Self-checking testbench for the line interface control and idle code register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import lific_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} lific_row_s;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic tx_line_clock_i = 1'b0;
  logic tx_chan_valid_i = 1'b0;
  logic [4:0] tx_chan_i = 5'h00;
  logic [7:0] tx_chan_data_i = 8'h00;
  logic [7:0] rd_data_o;
  logic tx_chan_valid_o;
  logic [7:0] tx_chan_data_o;
  logic [5:0] monitor_gain_db_o;
  logic rx_sync_mode_o;
  logic tx_sync_clock_en_o;
  logic alt_pattern_active_o;
  logic alt_pattern_o;
  logic cmi_enable_o;
  logic cmi_invert_tx_o;
  logic cmi_invert_rx_o;
  logic [14:0] mclk_khz_o;
  logic [6:0] tx_term_ohm_o;
  logic [6:0] rx_term_ohm_o;
  logic e1_mode_o;
  logic [5:0] gain_adjust_code_o;
  logic signed [7:0] amplitude_pct_o;
  logic [1:0] slew_reduce_o;
  logic [4:0] slew_boost_a_o;
  logic slew_boost_b_o;
  logic [1:0] v;
  logic [2:0] a3;
  int cycles = 0;
  int fails = 0;
  int samples_checked = 0;
  // Ordinary write and read-back cases: address, write value, read-back value
  lific_row_s rows [9] = '{'{OFS_LIC4, 8'hA5, 8'hA5}, '{OFS_PTR, 8'h3F, 8'h3F},
    '{OFS_TXEN1, 8'h81, 8'h81}, '{OFS_PSA1, 8'hFF, 8'h3F}, '{OFS_PSA2, 8'hFF, 8'h88},
    '{OFS_TLBC, 8'hFF, 8'h40}, '{OFS_LIC2, 8'hFF, 8'h88}, '{OFS_CFG, 8'hFF, 8'h01},
    '{8'h44, 8'hFF, 8'h00}};
  logic [15:0] gain_exp [4] = '{16'h0000, 16'h0014, 16'h001A, 16'h0020};
  logic [15:0] ohm_exp [4] = '{16'h0000, 16'h004B, 16'h0064, 16'h0078};
  logic [7:0] pct_exp [8] = '{8'h00, 8'hE9, 8'hF1, 8'hF8, 8'h06, 8'h0A, 8'h0F, 8'h23};

  lific_regs dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .tx_line_clock_i(tx_line_clock_i), .tx_chan_valid_i(tx_chan_valid_i),
    .tx_chan_i(tx_chan_i), .tx_chan_data_i(tx_chan_data_i), .tx_chan_valid_o(tx_chan_valid_o),
    .tx_chan_data_o(tx_chan_data_o), .monitor_gain_db_o(monitor_gain_db_o),
    .rx_sync_mode_o(rx_sync_mode_o), .tx_sync_clock_en_o(tx_sync_clock_en_o),
    .alt_pattern_active_o(alt_pattern_active_o), .alt_pattern_o(alt_pattern_o),
    .cmi_enable_o(cmi_enable_o), .cmi_invert_tx_o(cmi_invert_tx_o),
    .cmi_invert_rx_o(cmi_invert_rx_o), .mclk_khz_o(mclk_khz_o), .tx_term_ohm_o(tx_term_ohm_o),
    .rx_term_ohm_o(rx_term_ohm_o), .e1_mode_o(e1_mode_o),
    .gain_adjust_code_o(gain_adjust_code_o), .amplitude_pct_o(amplitude_pct_o),
    .slew_reduce_o(slew_reduce_o), .slew_boost_a_o(slew_boost_a_o),
    .slew_boost_b_o(slew_boost_b_o));

  // 10 MHz clock
  always #50 mclk_i = ~mclk_i;

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge mclk_i);
    wr_en_i <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data stands only in the next cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge mclk_i);
    rd_en_i <= 1'b0;
    #1;
    check_val(16'(rd_data_o), 16'(e));
    @(posedge mclk_i);
    #1;
    check_val(16'(rd_data_o), 16'h0000);
  endtask : rd_chk

  // Decoded outputs follow the register one cycle later
  task automatic settle();
    @(posedge mclk_i);
    #1;
  endtask : settle

  // One channel byte through the transmit stream
  task automatic ch(input logic [4:0] c, input logic [7:0] d, input logic [7:0] e);
    @(posedge mclk_i);
    tx_chan_valid_i <= 1'b1;
    tx_chan_i <= c;
    tx_chan_data_i <= d;
    @(posedge mclk_i);
    tx_chan_valid_i <= 1'b0;
    #1;
    check_val({8'h00, tx_chan_data_o}, {8'h00, e});
    check_val(16'(tx_chan_valid_o), 16'h0001);
  endtask : ch

  // Line clock level held long enough to pass the filter
  task automatic line_clk(input logic lvl);
    @(posedge mclk_i);
    tx_line_clock_i <= lvl;
    repeat (8) @(posedge mclk_i);
    #1;
  endtask : line_clk

  // Main sequence
  initial
  begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) rd_chk(rows[i].a, 8'h00);
    rd_chk(OFS_CODE, 8'h00);
    $display("test %s done", "reset");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    foreach (rows[i]) wr(rows[i].a, 8'h00);
    $display("test %s done", "rows");
    for (int g = 0; g < 4; g++)
    begin
      v = 2'(g);
      wr(OFS_LIC3, {3'b000, v, v, 1'b0});
      settle();
      check_val(16'(monitor_gain_db_o), gain_exp[v]);
      check_val(16'(rx_sync_mode_o), 16'(v[1]));
      check_val(16'(tx_sync_clock_en_o), 16'(v[0]));
    end
    for (int m = 0; m < 12; m++)
    begin
      v = 2'(m);
      wr(OFS_LIC2, (m < 4) ? 8'h00 : ((m < 8) ? 8'h08 : 8'h80));
      wr(OFS_LIC4, {v, v, v, ~v});
      settle();
      check_val(16'(mclk_khz_o), (m < 4) ? (16'h0608 << v) : (16'h0800 << v));
      check_val(16'(tx_term_ohm_o), ohm_exp[v]);
      check_val(16'(rx_term_ohm_o), ohm_exp[~v]);
      check_val(16'({cmi_enable_o, cmi_invert_tx_o}), 16'(v));
      check_val(16'(cmi_invert_rx_o), 16'(v[0]));
      check_val(16'(e1_mode_o), 16'(m >= 8));
    end
    wr(OFS_LIC2, 8'h00);
    $display("test %s done", "line control");
    for (int t = 0; t < 16; t++)
    begin
      a3 = 3'(t);
      wr(OFS_TLBC, (t < 8) ? 8'h00 : 8'h40);
      wr(OFS_PSA1, {2'b00, a3[2], a3[1], a3[1], a3[0], a3[0], a3[2]});
      wr(OFS_PSA2, {a3[1], 3'b000, a3[0], 3'b000});
      settle();
      check_val({8'h00, amplitude_pct_o}, (t < 8) ? {8'h00, pct_exp[a3]} : 16'h0000);
      check_val(16'(gain_adjust_code_o),
        (t < 8) ? 16'({a3[2], 1'b0, a3[1], 1'b0, a3[0], 1'b0}) : 16'h0000);
      check_val(16'(slew_reduce_o), 16'({a3[1], a3[0]}));
      check_val(16'(slew_boost_a_o), 16'(8 * (int'(a3[1]) + int'(a3[0]))));
      check_val(16'(slew_boost_b_o), 16'(a3[2]));
    end
    $display("test %s done", "pulse shape");
    wr(OFS_LIC3, 8'h01);
    settle();
    check_val(16'({alt_pattern_active_o, alt_pattern_o}), 16'h0002);
    for (int k = 1; k <= 4; k++)
    begin
      line_clk(1'b1);
      check_val(16'(alt_pattern_o), 16'(k % 2));
      line_clk(1'b0);
    end
    wr(OFS_LIC3, 8'h00);
    settle();
    check_val(16'(alt_pattern_o), 16'h0000);
    $display("test %s done", "alternating pattern");
    wr(OFS_TXEN1, 8'h01);
    wr(OFS_PTR, 8'h01);
    wr(OFS_CODE, 8'h3C);
    ch(5'h00, 8'h55, 8'h3C);
    ch(5'h01, 8'h55, 8'h55);
    rd_chk(OFS_CODE, 8'h3C);
    wr(OFS_TXEN4, 8'h81);
    wr(OFS_PTR, 8'h19);
    wr(OFS_CODE, 8'hEE);
    ch(5'h18, 8'h11, 8'h00);
    wr(OFS_PTR, 8'h01);
    ch(5'h00, 8'h11, 8'h3C);
    wr(OFS_PTR, 8'h41);
    wr(OFS_CODE, 8'h81);
    rd_chk(OFS_CODE, 8'h81);
    wr(OFS_TXEN4, 8'h80);
    ch(5'h1F, 8'h22, 8'h81);
    ch(5'h00, 8'h22, 8'h81);
    wr(OFS_PTR, 8'h81);
    wr(OFS_CODE, 8'h5A);
    wr(OFS_CFG, 8'h01);
    wr(OFS_PTR, 8'h18);
    rd_chk(OFS_CODE, 8'h5A);
    wr(OFS_CFG, 8'h00);
    rd_chk(OFS_CODE, 8'h81);
    wr(OFS_PTR, 8'hC1);
    wr(OFS_CODE, 8'h77);
    wr(OFS_PTR, 8'h18);
    rd_chk(OFS_CODE, 8'h77);
    wr(OFS_CFG, 8'h01);
    rd_chk(OFS_CODE, 8'h77);
    wr(OFS_CFG, 8'h00);
    wr(OFS_LIC2, 8'h80);
    wr(OFS_PTR, 8'h20);
    wr(OFS_CODE, 8'h99);
    ch(5'h1F, 8'h22, 8'h99);
    $display("test %s done", "idle code");
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) rd_chk(rows[i].a, 8'h00);
    ch(5'h1F, 8'h42, 8'h42);
    $display("test %s done", "second reset");
    give_verdict();
  end
endmodule : testbench
